// *** core/watchdog_and_reset_cause.sv ***
/*
  Watchdog timer with reset-cause status register, APB slave.
  Assumes presetn is the power-on reset, the other reset sources come
  in as one-cycle pulses on pclk, and wdt_osc_clk is a free-running
  on-chip oscillator unrelated to pclk.
*/
//
// Functional notes
// R1: reset-cause bits 7..4 always read zero.
// R2: watchdog reset flag sets on watchdog reset; cleared by POR or write zero.
// R3: brown-out flag sets on brown-out reset; cleared by POR or write zero.
// R4: external flag sets on pin reset; cleared by POR or write zero.
// R5: power-on flag set by POR; only a software zero write clears it.
// R6: software reads then clears reset-cause early after start-up.
// R7: counter counts the separate slow oscillator, not the system clock.
// R8: restart clears counter; missing restart before time-out triggers action.
// R9: time-out period selectable from shortest to longest setting.
// R10: interrupt mode raises interrupt without reset; usable as wake-up.
// R11: reset mode expiry issues a system reset.
// R12: combined mode interrupts first, then falls into reset mode.
// R13: always-on fuse forces reset enable one and interrupt enable zero.
// R14: software unlocks by writing change enable and reset enable together.
// R15: new reset enable and prescaler taken only within four cycles; here a reset enable of one is taken at any time.
// R16: after an accidental watchdog reset the watchdog stays enabled.
// R17: init software clears watchdog flag and reset enable always.
// R18: reset enable reads set and cannot clear while watchdog flag set.
// R19: change enable clears by itself four cycles after being written.
// R20: time-out with interrupt sets flag; vector entry or write one clears.
// R21: prescaler code 0 gives 2048 cycles, doubling up to code 9.
// R22: commands cross into oscillator domain and expiry back safely.
`timescale 1ns/100ps
module watchdog_and_reset_cause
  import wdt_pkg::*;
#(
  parameter int TIMEOUT_BASE = wdt_pkg::TIMEOUT_BASE_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wdt_osc_clk,
  input  wire logic        restart_cmd,
  input  wire logic        vector_ack,
  input  wire logic        watchdog_always_on_fuse,
  input  wire logic        brownout_event,
  input  wire logic        ext_reset_event,
  output logic             wdt_irq,
  output logic             wdt_sys_reset
);
  import wdt_pkg::*;

  // ***************************************************************
  // pclk domain state
  // ***************************************************************
  logic [3:0]  cause_ff,  nxt_cause;
  logic        timeout_interrupt_flag_ff,   nxt_timeout_interrupt_flag;
  logic        interrupt_enable_bit_ff,   nxt_interrupt_enable_bit;
  logic        wde_ff,    nxt_wde;
  logic [3:0]  psc_ff,    nxt_psc;
  logic [2:0]  chg_ff,    nxt_chg;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        perr_ff,   nxt_perr;
  logic        irq_ff,    nxt_irq;
  logic        srst_ff,   nxt_srst;
  logic        rst_tgl_ff, nxt_rst_tgl;
  logic [1:0]  rst_ack_ff;
  logic        run_ff,    nxt_run;
  logic        osc_exp_tgl_ff, nxt_osc_exp_tgl;
  logic [2:0]  rst_sync_ff;
  logic [2:0]  exp_sync_ff;

  logic        wde_eff, interrupt_enable_bit_eff, expiry;
  logic        wr_acc, wr_cause, wr_ctrl, hit_cause, hit_ctrl, unlock;
  logic [7:0]  ctrl_rd;

  // R13 R18
  assign wde_eff  = wde_ff | cause_ff[WDR_FLAG_BIT] | watchdog_always_on_fuse;
  assign interrupt_enable_bit_eff = interrupt_enable_bit_ff & ~watchdog_always_on_fuse; // R13
  assign nxt_run  = wde_eff | interrupt_enable_bit_eff;
  // back-crossed expiry toggle; stage 0 feeds stage 1 only
  assign expiry   = exp_sync_ff[2] ^ exp_sync_ff[1]; // R22

  assign hit_cause = (paddr == RESET_CAUSE_OFS);
  assign hit_ctrl  = (paddr == WDT_CTRL_OFS);
  assign wr_acc    = psel & penable & pready_ff & pwrite;
  assign wr_cause  = wr_acc & hit_cause;
  assign wr_ctrl   = wr_acc & hit_ctrl;
  assign unlock    = wr_ctrl & pwdata[CHG_EN_BIT] & pwdata[RST_EN_BIT]; // R14

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[IRQ_FLAG_BIT] = timeout_interrupt_flag_ff;
    ctrl_rd[IRQ_EN_BIT]   = interrupt_enable_bit_eff;
    ctrl_rd[PSC_HI_BIT]   = psc_ff[3];
    ctrl_rd[CHG_EN_BIT]   = (chg_ff != 3'h0);
    ctrl_rd[RST_EN_BIT]   = wde_eff; // R18
    ctrl_rd[PSC_LO_BIT +: 3] = psc_ff[2:0];
  end

  always_comb begin
    nxt_cause   = cause_ff;
    nxt_timeout_interrupt_flag    = timeout_interrupt_flag_ff;
    nxt_interrupt_enable_bit    = interrupt_enable_bit_ff;
    nxt_wde     = wde_ff;
    nxt_psc     = psc_ff;
    nxt_chg     = (chg_ff != 3'h0) ? chg_ff - 3'h1 : 3'h0; // R19
    nxt_srst    = 1'b0;
    nxt_rst_tgl = rst_tgl_ff;
    // software zero writes clear reset-cause flags; writing one keeps them
    if (wr_cause) begin
      nxt_cause = cause_ff & pwdata[3:0]; // R2 R3 R4 R5
    end
    if (wr_ctrl) begin
      if (pwdata[IRQ_FLAG_BIT]) begin
        nxt_timeout_interrupt_flag = 1'b0; // R20
      end
      nxt_interrupt_enable_bit = pwdata[IRQ_EN_BIT];
      if (unlock) begin
        nxt_chg = CHG_WINDOW_CYC; // R14
        nxt_wde = 1'b1;
      end else if (chg_ff != 3'h0 && !pwdata[CHG_EN_BIT]) begin
        nxt_wde = pwdata[RST_EN_BIT]; // R15
        nxt_psc = {pwdata[PSC_HI_BIT], pwdata[PSC_LO_BIT +: 3]};
        nxt_chg = 3'h0;
      end else begin
        // enabling is never locked; disabling needs the window
        nxt_wde = wde_ff | pwdata[RST_EN_BIT];
      end
    end
    if (vector_ack) begin
      nxt_timeout_interrupt_flag = 1'b0; // R20
      if (wde_eff && interrupt_enable_bit_eff) begin
        nxt_interrupt_enable_bit = 1'b0; // R12
      end
    end
    // events are applied last so a set beats a same-cycle clear
    if (expiry) begin
      if (interrupt_enable_bit_eff && !(wde_eff && timeout_interrupt_flag_ff)) begin
        nxt_timeout_interrupt_flag = 1'b1; // R10 R12 R20
      end else if (wde_eff) begin
        nxt_srst = 1'b1; // R11 R12 R13
        nxt_cause[WDR_FLAG_BIT] = 1'b1; // R2 R16
      end
    end
    // dropped while one is in flight; that clear lags it by a few wdt_osc_clk cycles
    if (restart_cmd && rst_ack_ff[1] == rst_tgl_ff) begin
      nxt_rst_tgl = ~rst_tgl_ff; // R8 R22
    end
    if (brownout_event) begin
      nxt_cause[BOR_FLAG_BIT] = 1'b1; // R3
    end
    if (ext_reset_event) begin
      nxt_cause[EXT_FLAG_BIT] = 1'b1; // R4
    end
    nxt_irq = nxt_timeout_interrupt_flag & (nxt_interrupt_enable_bit & ~watchdog_always_on_fuse);
  end

  // ***************************************************************
  // apb slave: zero wait state access, answer in access phase
  // ***************************************************************
  always_comb begin
    nxt_pready = 1'b0;
    nxt_prdata = 32'h0000_0000;
    nxt_perr   = 1'b0;
    if (psel && !penable) begin
      nxt_pready = 1'b1;
      nxt_perr   = ~(hit_cause | hit_ctrl);
      if (!pwrite && hit_cause) begin
        nxt_prdata = {28'h000_0000, cause_ff}; // R1
      end else if (!pwrite && hit_ctrl) begin
        nxt_prdata = {24'h00_0000, ctrl_rd};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff    <= CAUSE_RESET_VAL; // R5
      timeout_interrupt_flag_ff     <= 1'b0;
      interrupt_enable_bit_ff     <= 1'b0;
      wde_ff      <= 1'b0;
      psc_ff      <= PSC_RESET_VAL;
      chg_ff      <= 3'h0;
      prdata_ff   <= 32'h0000_0000;
      pready_ff   <= 1'b0;
      perr_ff     <= 1'b0;
      irq_ff      <= 1'b0;
      srst_ff     <= 1'b0;
      rst_tgl_ff  <= 1'b0;
      exp_sync_ff <= 3'h0;
      rst_ack_ff  <= 2'h0;
      run_ff      <= 1'b0;
    end else begin
      cause_ff    <= nxt_cause;
      timeout_interrupt_flag_ff     <= nxt_timeout_interrupt_flag;
      interrupt_enable_bit_ff     <= nxt_interrupt_enable_bit;
      wde_ff      <= nxt_wde;
      psc_ff      <= nxt_psc;
      chg_ff      <= nxt_chg;
      prdata_ff   <= nxt_prdata;
      pready_ff   <= nxt_pready;
      perr_ff     <= nxt_perr;
      irq_ff      <= nxt_irq;
      srst_ff     <= nxt_srst;
      rst_tgl_ff  <= nxt_rst_tgl;
      exp_sync_ff <= {exp_sync_ff[1:0], osc_exp_tgl_ff};
      rst_ack_ff  <= {rst_ack_ff[0], rst_sync_ff[2]}; // R22
      run_ff      <= nxt_run;
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = perr_ff;
  assign wdt_irq       = irq_ff;
  assign wdt_sys_reset = srst_ff;

  // ***************************************************************
  // oscillator domain counter
  // ***************************************************************
  // prescaler bits cross as quiet levels; restart before changing it
  logic [1:0]  run_sync_ff;
  logic [3:0]  psc_s0_ff, psc_s1_ff;
  logic [20:0] cnt_ff, nxt_cnt;
  logic [3:0]  psc_eff;
  logic [20:0] limit;
  logic        osc_restart;

  assign osc_restart = rst_sync_ff[2] ^ rst_sync_ff[1]; // R22
  assign psc_eff = (psc_s1_ff > PSC_MAX_CODE) ? PSC_MAX_CODE : psc_s1_ff;
  assign limit   = (21'(TIMEOUT_BASE) << psc_eff) - 21'h1; // R9 R21

  always_comb begin
    nxt_cnt         = cnt_ff + 21'h1; // R7
    nxt_osc_exp_tgl = osc_exp_tgl_ff;
    if (!run_sync_ff[1] || osc_restart) begin
      nxt_cnt = 21'h0; // R8
    end else if (cnt_ff >= limit) begin
      nxt_cnt         = 21'h0;
      nxt_osc_exp_tgl = ~osc_exp_tgl_ff; // R8 R22
    end
  end

  always_ff @(posedge wdt_osc_clk or negedge presetn) begin
    if (!presetn) begin
      run_sync_ff    <= 2'h0;
      psc_s0_ff      <= PSC_RESET_VAL;
      psc_s1_ff      <= PSC_RESET_VAL;
      rst_sync_ff    <= 3'h0;
      cnt_ff         <= 21'h0;
      osc_exp_tgl_ff <= 1'b0;
    end else begin
      run_sync_ff    <= {run_sync_ff[0], run_ff};
      psc_s0_ff      <= psc_ff;
      psc_s1_ff      <= psc_s0_ff;
      rst_sync_ff    <= {rst_sync_ff[1:0], rst_tgl_ff};
      cnt_ff         <= nxt_cnt;
      osc_exp_tgl_ff <= nxt_osc_exp_tgl;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_rsvd_zero;
    @(posedge pclk) disable iff (!presetn)
      (pready_ff && hit_cause && !pwrite) |-> (prdata_ff[31:4] == 28'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // R1
    else $error("reserved cause bits not zero");

  property p_wdr_flag;
    @(posedge pclk) disable iff (!presetn)
      srst_ff |-> cause_ff[WDR_FLAG_BIT] ##1 wde_eff;
  endproperty
  a_wdr_flag: assert property (p_wdr_flag) // R2
    else $error("watchdog reset without flag");

  property p_bor_flag;
    @(posedge pclk) disable iff (!presetn)
      brownout_event |=> cause_ff[BOR_FLAG_BIT];
  endproperty
  a_bor_flag: assert property (p_bor_flag) // R3
    else $error("brown-out flag not set");

  property p_ext_flag;
    @(posedge pclk) disable iff (!presetn)
      ext_reset_event |=> cause_ff[EXT_FLAG_BIT];
  endproperty
  a_ext_flag: assert property (p_ext_flag) // R4
    else $error("external flag not set");

  property p_chg_clear;
    @(posedge pclk) disable iff (!presetn)
      (unlock || (chg_ff != 3'h0 && !wr_ctrl)) |=>
        (chg_ff == ($past(unlock) ? CHG_WINDOW_CYC : $past(chg_ff) - 3'h1));
  endproperty
  a_chg_clear: assert property (p_chg_clear) // R19
    else $error("change enable window length wrong");

  property p_locked;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctrl && chg_ff == 3'h0 && wde_ff) |=> wde_ff && $stable(psc_ff);
  endproperty
  a_locked: assert property (p_locked) // R15
    else $error("locked setting changed");

  property p_fuse_reset;
    @(posedge pclk) disable iff (!presetn)
      (expiry && watchdog_always_on_fuse) |=> srst_ff && !timeout_interrupt_flag_ff;
  endproperty
  a_fuse_reset: assert property (p_fuse_reset) // R13
    else $error("fuse did not force reset mode");

  property p_irq_mode;
    @(posedge pclk) disable iff (!presetn)
      (expiry && interrupt_enable_bit_eff && !wde_eff) |=> timeout_interrupt_flag_ff && !srst_ff ##1 wdt_irq;
  endproperty
  a_irq_mode: assert property (p_irq_mode) // R10
    else $error("interrupt mode misbehaved");

  property p_restart;
    @(posedge wdt_osc_clk) disable iff (!presetn)
      osc_restart |=> (cnt_ff == 21'h0);
  endproperty
  a_restart: assert property (p_restart) // R8
    else $error("restart did not clear counter");

endmodule // watchdog_and_reset_cause

// *** core/wdt_pkg.sv ***
/*
  Constants shared by the watchdog and reset-cause block: register
  offsets, field positions, reset values and timing counts.
  Assumes a 32-bit APB register port with word-aligned registers.
*/
package wdt_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [11:0] RESET_CAUSE_OFS  = 12'h000;
  localparam logic [11:0] WDT_CTRL_OFS     = 12'h004;

  // reset_cause_status fields
  localparam int          POR_FLAG_BIT     = 0;
  localparam int          EXT_FLAG_BIT     = 1;
  localparam int          BOR_FLAG_BIT     = 2;
  localparam int          WDR_FLAG_BIT     = 3;
  localparam logic [3:0]  CAUSE_RESET_VAL  = 4'h1;

  // watchdog_control_status fields
  localparam int          PSC_LO_BIT       = 0;
  localparam int          RST_EN_BIT       = 3;
  localparam int          CHG_EN_BIT       = 4;
  localparam int          PSC_HI_BIT       = 5;
  localparam int          IRQ_EN_BIT       = 6;
  localparam int          IRQ_FLAG_BIT     = 7;
  localparam logic [3:0]  PSC_RESET_VAL    = 4'h0;
  localparam logic [3:0]  PSC_MAX_CODE     = 4'h9;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int          OSC_FREQ_HZ      = 128000;
  localparam int          TIMEOUT_BASE_DEF = 2048;
  localparam logic [2:0]  CHG_WINDOW_CYC   = 3'h4;

endpackage : wdt_pkg

// *** dv/test_watchdog_and_reset_cause.sv ***
/*
  Self-checking bench for the watchdog and reset-cause block.
  Assumes wdt_pkg is compiled first; the oscillator runs far above its
  nominal rate and the time-out base is shrunk so time-outs stay short.
*/
`timescale 1ns/100ps
module test_watchdog_and_reset_cause;
  import wdt_pkg::*;

  localparam int BASE     = 16;
  localparam int OSC_HALF = 70;
  localparam int STEP     = BASE * 2 * OSC_HALF / 25;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wdt_osc_clk;
  logic        restart_cmd;
  logic        vector_ack;
  logic        fuse;
  logic        brownout_event;
  logic        ext_reset_event;
  logic        wdt_irq;
  logic        wdt_sys_reset;
  int          error_cnt;
  int          checked;
  int          rst_cnt;
  int          t0;
  int          t1;

  watchdog_and_reset_cause #(.TIMEOUT_BASE(BASE)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdt_osc_clk(wdt_osc_clk),
    .restart_cmd(restart_cmd), .vector_ack(vector_ack),
    .watchdog_always_on_fuse(fuse), .brownout_event(brownout_event),
    .ext_reset_event(ext_reset_event), .wdt_irq(wdt_irq),
    .wdt_sys_reset(wdt_sys_reset)
  );

  // ***************************************************************
  // clocks and watchdog reset counting
  // ***************************************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // phase offset keeps the two domains unrelated
  initial begin
    wdt_osc_clk = 1'b0;
    #13;
    forever #OSC_HALF wdt_osc_clk = ~wdt_osc_clk;
  end

  always @(posedge pclk) begin
    if (wdt_sys_reset === 1'b1) rst_cnt <= rst_cnt + 1;
  end

  // ***************************************************************
  // tasks
  // ***************************************************************
  task finish_test;
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task err(input string m);
    error_cnt++;
    $display("ERROR at %0t: %s", $time, m);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // hold keeps psel up so the next setup follows at once
  task xfer(input logic [11:0] a, input logic w, input logic [7:0] d,
            input bit hold, output logic [31:0] r, output logic e);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err("no pready");
    r = prdata;
    e = pslverr;
    if (!hold) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d, input bit hold);
    logic [31:0] r;
    logic        e;
    xfer(a, 1'b1, d, hold, r, e);
  endtask

  task rd(input logic [11:0] a, input logic [7:0] exp, input logic xe);
    logic [31:0] r;
    logic        e;
    xfer(a, 1'b0, 8'h00, 1'b0, r, e);
    chk(r, {24'h00_0000, exp});
    chk({31'h0000_0000, e}, {31'h0000_0000, xe});
  endtask

  task pulse(input int k);
    case (k)
      0: restart_cmd <= 1'b1;
      1: brownout_event <= 1'b1;
      2: ext_reset_event <= 1'b1;
      default: vector_ack <= 1'b1;
    endcase
    @(posedge pclk);
    restart_cmd     <= 1'b0;
    brownout_event  <= 1'b0;
    ext_reset_event <= 1'b0;
    vector_ack      <= 1'b0;
    @(posedge pclk);
  endtask

  task wait_irq(output int n);
    n = 0;
    while (wdt_irq !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) err("no interrupt");
  endtask

  task wait_rst;
    int n;
    int c;
    c = rst_cnt;
    n = 0;
    while (rst_cnt == c && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (rst_cnt == c) err("no watchdog reset");
  endtask

  // restart-to-interrupt time for one prescaler code, flag left clear
  task measure(input logic [7:0] psc, output int t);
    wr(WDT_CTRL_OFS, 8'h18, 1'b1);
    wr(WDT_CTRL_OFS, psc, 1'b0);
    wr(WDT_CTRL_OFS, 8'h40 | psc, 1'b0);
    pulse(0);
    wait_irq(t);
    wr(WDT_CTRL_OFS, 8'hC0 | psc, 1'b0);
    pulse(0);
    wait_irq(t);
    wr(WDT_CTRL_OFS, 8'h80 | psc, 1'b0);
  endtask

  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    repeat (60000) @(posedge pclk);
    err("run timeout");
    finish_test();
  end

  initial begin
    error_cnt = 0; checked = 0; rst_cnt = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; restart_cmd = 1'b0;
    vector_ack = 1'b0; fuse = 1'b0; brownout_event = 1'b0;
    ext_reset_event = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(RESET_CAUSE_OFS, 8'h01, 1'b0);
    rd(WDT_CTRL_OFS, 8'h00, 1'b0);
    rd(12'h008, 8'h00, 1'b1);
    pulse(1);
    pulse(2);
    rd(RESET_CAUSE_OFS, 8'h07, 1'b0);
    wr(RESET_CAUSE_OFS, 8'hFE, 1'b0);
    rd(RESET_CAUSE_OFS, 8'h06, 1'b0);
    wr(RESET_CAUSE_OFS, 8'hF0, 1'b0);
    rd(RESET_CAUSE_OFS, 8'h00, 1'b0);
    pulse(0);
    wr(WDT_CTRL_OFS, 8'h39, 1'b1);
    wr(WDT_CTRL_OFS, 8'h21, 1'b0);
    rd(WDT_CTRL_OFS, 8'h21, 1'b0);
    wr(WDT_CTRL_OFS, 8'h39, 1'b1);
    rd(WDT_CTRL_OFS, 8'h39, 1'b0);
    repeat (4) @(posedge pclk);
    rd(WDT_CTRL_OFS, 8'h29, 1'b0);
    wr(WDT_CTRL_OFS, 8'h21, 1'b0);
    rd(WDT_CTRL_OFS, 8'h29, 1'b0);
    measure(8'h00, t0);
    measure(8'h01, t1);
    chk(32'((t1 - t0 > STEP - 8) && (t1 - t0 < STEP + 8)), 32'h0000_0001);
    rd(WDT_CTRL_OFS, 8'h01, 1'b0);
    chk(32'(wdt_irq), 32'h0000_0000);
    chk(32'(rst_cnt), 32'h0000_0000);
    wr(WDT_CTRL_OFS, 8'h49, 1'b0);
    pulse(0);
    wait_irq(t0);
    chk(32'(rst_cnt), 32'h0000_0000);
    pulse(3);
    rd(WDT_CTRL_OFS, 8'h09, 1'b0);
    wait_rst();
    chk(32'(rst_cnt), 32'h0000_0001);
    rd(RESET_CAUSE_OFS, 8'h08, 1'b0);
    repeat (20) begin
      pulse(0);
      repeat (38) @(posedge pclk);
    end
    chk(32'(rst_cnt), 32'h0000_0001);
    wr(WDT_CTRL_OFS, 8'h19, 1'b1);
    wr(WDT_CTRL_OFS, 8'h01, 1'b0);
    rd(WDT_CTRL_OFS, 8'h09, 1'b0);
    wr(RESET_CAUSE_OFS, 8'h00, 1'b0);
    rd(RESET_CAUSE_OFS, 8'h00, 1'b0);
    wr(WDT_CTRL_OFS, 8'h19, 1'b1);
    wr(WDT_CTRL_OFS, 8'h01, 1'b0);
    rd(WDT_CTRL_OFS, 8'h01, 1'b0);
    pulse(0);
    fuse <= 1'b1;
    rd(WDT_CTRL_OFS, 8'h09, 1'b0);
    wr(WDT_CTRL_OFS, 8'h41, 1'b0);
    rd(WDT_CTRL_OFS, 8'h09, 1'b0);
    wait_rst();
    chk(32'(rst_cnt), 32'h0000_0002);
    fuse <= 1'b0;
    finish_test();
  end

endmodule // test_watchdog_and_reset_cause
